// file: include/opw_pkg.sv
// Constants and types shared by the word programming controller
package opw_pkg;
  localparam logic [31:0] ADDR_MODE      = 32'h07F40000;
  localparam logic [31:0] ADDR_PCTRL     = 32'h07F40004;
  localparam logic [31:0] ADDR_STAT      = 32'h07F40008;
  localparam logic [31:0] ADDR_PWORD0    = 32'h07F40010;
  localparam logic [31:0] ADDR_PWORD1    = 32'h07F40014;

  localparam int          MODE_LSB       = 0;
  localparam int          MODE_W         = 3;
  localparam logic [2:0]  MODE_MANUAL_PROG = 3'h2;
  localparam logic [2:0]  MODE_RESET     = 3'h0;

  localparam int          PCTRL_LOC_LSB  = 0;
  localparam int          PCTRL_LOC_W    = 13;
  localparam int          PCTRL_RETRY_BIT = 14;
  localparam int          PCTRL_START_BIT = 15;
  localparam logic [31:0] PCTRL_RESET    = 32'h00000000;

  localparam int          STAT_READY_BIT = 0;
  localparam int          STAT_FAIL_BIT  = 2;
  localparam int          STAT_ZERO_BIT  = 3;

  localparam int          DATA_W         = 64;
  localparam int          CHECK_W        = 8;
  localparam int          WORD_W         = 72;
  localparam logic [31:0] PWORD_RESET    = 32'h00000000;

  typedef enum logic [0:0] {
    OPW_IDLE,
    OPW_PROG
  } opw_fsm_type;
endpackage

// file: core/opw_fail_mem.sv
// Record of the bits that failed in the last programming attempt
`timescale 1ns/1ps
`default_nettype none
module opw_fail_mem #(
  parameter int WIDTH = 72
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output var  logic [WIDTH-1:0] rd_data
);
  typedef struct packed {
    logic [WIDTH-1:0] bits;
  } opw_mem_type;

  opw_mem_type st;
  opw_mem_type next_st;

  initial begin
    if (WIDTH < 1) $error("opw_fail_mem: WIDTH must be positive");
  end

  always_comb begin
    next_st = st;
    if (wr_en) begin
      next_st.bits = wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.bits;
endmodule // opw_fail_mem
`default_nettype wire

// file: core/opw_prog_ctrl.sv
// Manual one-word programming control with Avalon-MM register slave
// Behaviour
// - In manual programming mode a one written to start bit 15 launches programming of exactly one word.
// - The start bit clears itself and always reads back as zero.
// - The programmed data are the 64 bits of the two data word registers.
// - Location bits 12:0 choose the word that is programmed.
// - Each location is one 72-bit word of 64 data bits and 8 check bits.
// - Retry select at bit 14 low programs every one bit of the word as if the target were blank.
// - Retry select high programs only the bits that failed in the attempt just before.
// - The device keeps a record of the bits that failed in the previous attempt.
// - Manual programming mode is the mode field value 0x2.
// - A word to program that is all zero skips the sequence and sets the zero-word-skipped flag.
`timescale 1ns/1ps
`default_nettype none
module opw_prog_ctrl #(
  parameter int LOC_W  = 13,
  parameter int DATA_W = 64
) (
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST,
  input  wire logic [31:0]          AVS_ADDRESS,
  input  wire logic                 AVS_READ,
  input  wire logic                 AVS_WRITE,
  input  wire logic [31:0]          AVS_WRITEDATA,
  input  wire logic [3:0]           AVS_BYTEENABLE,
  output var  logic [31:0]          AVS_READDATA,
  output var  logic                 AVS_WAITREQUEST,
  output var  logic [LOC_W-1:0]     ARR_ADDR,
  output var  logic [DATA_W+7:0]    ARR_BITS,
  output var  logic                 ARR_PROG,
  input  wire logic                 ARR_DONE,
  input  wire logic [DATA_W+7:0]    ARR_FAIL
);
  localparam int WORD_W = DATA_W + opw_pkg::CHECK_W;

  typedef struct packed {
    opw_pkg::opw_fsm_type      fsm;
    logic                      ack;
    logic [31:0]               rdata;
    logic [2:0]                mode;
    logic                      retry;
    logic [LOC_W-1:0]          loc;
    logic [31:0]               pword0;
    logic [31:0]               pword1;
    logic                      ready;
    logic                      zero_skip;
    logic                      failed;
    logic [LOC_W-1:0]          arr_addr;
    logic [WORD_W-1:0]         arr_bits;
    logic                      arr_prog;
  } opw_state_type;

  opw_state_type     st;
  opw_state_type     next_st;
  logic [WORD_W-1:0] fail_rec;
  logic              rec_wr;
  logic [WORD_W-1:0] rec_data;

  initial begin
    if (LOC_W != opw_pkg::PCTRL_LOC_W) $error("opw_prog_ctrl: LOC_W must be 13");
    if (DATA_W != opw_pkg::DATA_W) $error("opw_prog_ctrl: DATA_W must be 64");
  end

  // Simple interleaved parity; check bit k covers data bits whose index mod 8 is k
  function automatic logic [opw_pkg::CHECK_W-1:0] check_bits(input logic [DATA_W-1:0] d);
    logic [opw_pkg::CHECK_W-1:0] c;
    c = '0;
    for (int i = 0; i < DATA_W; i++) begin
      c[i % opw_pkg::CHECK_W] = c[i % opw_pkg::CHECK_W] ^ d[i];
    end
    return c;
  endfunction

  // Merge a bus write into a register under the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] pctrl_view(input logic rt, input logic [LOC_W-1:0] lc);
    logic [31:0] r;
    r = '0;
    r[opw_pkg::PCTRL_RETRY_BIT] = rt;
    r[opw_pkg::PCTRL_LOC_LSB +: LOC_W] = lc;
    return r;
  endfunction

  opw_fail_mem #(
    .WIDTH   (WORD_W)
  ) u_fail_mem (
    .clk     (CORE_CLK),
    .rst     (RST),
    .wr_en   (rec_wr),
    .wr_data (rec_data),
    .rd_data (fail_rec)
  );

  always_comb begin
    logic [DATA_W-1:0] data;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] pattern;
    logic [31:0]       pc_new;
    logic              do_wr;
    logic              start;
    data     = '0;
    word     = '0;
    pattern  = '0;
    pc_new   = '0;
    do_wr    = 1'b0;
    start    = 1'b0;
    next_st  = st;
    rec_wr   = 1'b0;
    rec_data = '0;

    // One wait cycle, then a single acknowledged cycle per transfer
    next_st.ack = (AVS_READ || AVS_WRITE) && !st.ack;
    do_wr = st.ack && AVS_WRITE;

    // Read data are captured a cycle early so the answer leaves a flip-flop
    next_st.rdata = '0;
    if (AVS_READ && !st.ack) begin
      unique case (AVS_ADDRESS)
        opw_pkg::ADDR_MODE:   next_st.rdata[opw_pkg::MODE_LSB +: opw_pkg::MODE_W] = st.mode;
        opw_pkg::ADDR_PCTRL:  next_st.rdata = pctrl_view(st.retry, st.loc);
        opw_pkg::ADDR_STAT: begin
          next_st.rdata[opw_pkg::STAT_READY_BIT] = st.ready;
          next_st.rdata[opw_pkg::STAT_FAIL_BIT]  = st.failed;
          next_st.rdata[opw_pkg::STAT_ZERO_BIT]  = st.zero_skip;
        end
        opw_pkg::ADDR_PWORD0: next_st.rdata = st.pword0;
        opw_pkg::ADDR_PWORD1: next_st.rdata = st.pword1;
        default:              next_st.rdata = '0;
      endcase
    end

    if (do_wr) begin
      unique case (AVS_ADDRESS)
        opw_pkg::ADDR_MODE: begin
          if (AVS_BYTEENABLE[0]) begin
            next_st.mode = AVS_WRITEDATA[opw_pkg::MODE_LSB +: opw_pkg::MODE_W];
          end
        end
        opw_pkg::ADDR_PCTRL: begin
          // Only retry and location are stored; start is a pure strobe
          pc_new = merge(pctrl_view(st.retry, st.loc), AVS_WRITEDATA, AVS_BYTEENABLE);
          next_st.retry = pc_new[opw_pkg::PCTRL_RETRY_BIT];
          next_st.loc   = pc_new[opw_pkg::PCTRL_LOC_LSB +: LOC_W];
          // Start is ignored outside manual programming mode or while busy
          start = AVS_BYTEENABLE[1] && AVS_WRITEDATA[opw_pkg::PCTRL_START_BIT]
                  && (st.mode == opw_pkg::MODE_MANUAL_PROG) && (st.fsm == opw_pkg::OPW_IDLE);
        end
        opw_pkg::ADDR_PWORD0: next_st.pword0 = merge(st.pword0, AVS_WRITEDATA, AVS_BYTEENABLE);
        opw_pkg::ADDR_PWORD1: next_st.pword1 = merge(st.pword1, AVS_WRITEDATA, AVS_BYTEENABLE);
        default: begin
        end
      endcase
    end

    data = {st.pword1, st.pword0};
    word = {check_bits(data), data};
    // A retry applies the intended value only where the last attempt failed
    if (next_st.retry) begin
      pattern = word & fail_rec;
    end else begin
      pattern = word;
    end

    unique case (st.fsm)
      opw_pkg::OPW_IDLE: begin
        if (start) begin
          if (pattern == '0) begin
            next_st.zero_skip = 1'b1;
            next_st.ready     = 1'b1;
          end else begin
            next_st.zero_skip = 1'b0;
            next_st.ready     = 1'b0;
            next_st.arr_addr  = next_st.loc;
            next_st.arr_bits  = pattern;
            next_st.arr_prog  = 1'b1;
            next_st.fsm       = opw_pkg::OPW_PROG;
          end
        end
      end
      opw_pkg::OPW_PROG: begin
        if (ARR_DONE) begin
          // Only bits actually attempted can be recorded as failed
          rec_wr           = 1'b1;
          rec_data         = ARR_FAIL & st.arr_bits;
          next_st.failed   = |(ARR_FAIL & st.arr_bits);
          next_st.arr_prog = 1'b0;
          next_st.ready    = 1'b1;
          next_st.fsm      = opw_pkg::OPW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st           <= '0;
      st.fsm       <= opw_pkg::OPW_IDLE;
      st.mode      <= opw_pkg::MODE_RESET;
      st.retry     <= opw_pkg::PCTRL_RESET[opw_pkg::PCTRL_RETRY_BIT];
      st.loc       <= opw_pkg::PCTRL_RESET[opw_pkg::PCTRL_LOC_LSB +: LOC_W];
      st.pword0    <= opw_pkg::PWORD_RESET;
      st.pword1    <= opw_pkg::PWORD_RESET;
      st.ready     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign AVS_READDATA    = st.rdata;
  assign AVS_WAITREQUEST = !st.ack;
  assign ARR_ADDR        = st.arr_addr;
  assign ARR_BITS        = st.arr_bits;
  assign ARR_PROG        = st.arr_prog;
endmodule // opw_prog_ctrl
`default_nettype wire

// file: test/opw_prog_ctrl_assertions.sv
// Concurrent checks on the bus and array ports of the programming controller
`timescale 1ns/1ps
`default_nettype none
module opw_prog_ctrl_assertions #(
  parameter int LOC_W  = 13,
  parameter int DATA_W = 64
) (
  input wire logic              CORE_CLK,
  input wire logic              RST,
  input wire logic [31:0]       AVS_ADDRESS,
  input wire logic              AVS_READ,
  input wire logic              AVS_WRITE,
  input wire logic [31:0]       AVS_WRITEDATA,
  input wire logic [3:0]        AVS_BYTEENABLE,
  input wire logic [31:0]       AVS_READDATA,
  input wire logic              AVS_WAITREQUEST,
  input wire logic [LOC_W-1:0]  ARR_ADDR,
  input wire logic [DATA_W+7:0] ARR_BITS,
  input wire logic              ARR_PROG,
  input wire logic              ARR_DONE,
  input wire logic [DATA_W+7:0] ARR_FAIL
);
  logic [2:0]        mode_q;
  logic [DATA_W+7:0] rec;
  logic              start_ok;
  // Mirror of mode and fail record, so a launch can be tied to its cause
  assign start_ok = AVS_WRITE && !AVS_WAITREQUEST && !ARR_PROG && AVS_ADDRESS == opw_pkg::ADDR_PCTRL
                    && AVS_WRITEDATA[15] && mode_q == opw_pkg::MODE_MANUAL_PROG;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mode_q <= '0;
      rec <= '0;
    end else begin
      if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == opw_pkg::ADDR_MODE)
        mode_q <= AVS_WRITEDATA[2:0];
      if (ARR_PROG && ARR_DONE)
        rec <= ARR_FAIL & ARR_BITS;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence s_start;
    start_ok;
  endsequence
  sequence s_retry;
    start_ok && AVS_WRITEDATA[14];
  endsequence
  chk_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST && AVS_READDATA == 32'h0)
    else $error("waitrequest low for more than one cycle");
  chk_ack_bound: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:2] !AVS_WAITREQUEST)
    else $error("bus request not answered");
  chk_pctrl_rsv: assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS == opw_pkg::ADDR_PCTRL
    |-> AVS_READDATA[31:15] == 17'h0 && !AVS_READDATA[13]) else $error("control reserved or start bit reads one");
  chk_launch_cause: assert property ($rose(ARR_PROG) |-> $past(start_ok))
    else $error("programming began without a start in manual mode");
  chk_loc_taken: assert property (s_start |=> !ARR_PROG || ARR_ADDR == $past(AVS_WRITEDATA[12:0]))
    else $error("programmed location differs from written location");
  chk_retry_subset: assert property (s_retry |=> !ARR_PROG || (ARR_BITS & ~rec) == '0)
    else $error("retry programs bits that did not fail");
  chk_prog_hold: assert property (ARR_PROG && !ARR_DONE |=> ARR_PROG && $stable(ARR_BITS) && $stable(ARR_ADDR))
    else $error("array request changed before done");
  chk_prog_drop: assert property (ARR_PROG && ARR_DONE |=> !ARR_PROG)
    else $error("array request outlived done");
  chk_zero_skip: assert property (ARR_PROG |-> ARR_BITS != '0)
    else $error("all-zero pattern sent to array");
endmodule // opw_prog_ctrl_assertions
bind opw_prog_ctrl opw_prog_ctrl_assertions #(.LOC_W(LOC_W), .DATA_W(DATA_W)) i_chk (.CORE_CLK(CORE_CLK),
  .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .ARR_ADDR(ARR_ADDR), .ARR_BITS(ARR_BITS), .ARR_PROG(ARR_PROG), .ARR_DONE(ARR_DONE), .ARR_FAIL(ARR_FAIL));
`default_nettype wire

// file: test/opw_array_model.sv
// Behavioural memory array answering one programming attempt at a time
`timescale 1ns/1ps
`default_nettype none
module opw_array_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        prog,
  input  wire logic [71:0] bits,
  input  wire logic [71:0] mask,
  input  wire logic [7:0]  lat,
  output var  logic        done,
  output var  logic [71:0] fail
);
  logic [7:0] cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      done <= 1'b0;
      fail <= '1;
    end else begin
      done <= 1'b0;
      fail <= ~fail; // Outside done the fail lines flip every cycle instead of holding the last result
      if (prog && !done) begin
        cnt <= cnt + 8'h01;
        if (cnt == lat) begin
          cnt <= '0;
          done <= 1'b1;
          fail <= bits & mask; // Masked bits refuse to program
        end
      end
    end
  end
endmodule // opw_array_model
`default_nettype wire

// file: test/tb.sv
// Register-level bench of the word programming controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic        CORE_CLK = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0, AVS_WAITREQUEST, ARR_PROG, ARR_DONE;
  logic [31:0] AVS_ADDRESS = '0, AVS_WRITEDATA = '0, AVS_READDATA, q;
  logic [12:0] ARR_ADDR, seen_addr;
  logic [71:0] ARR_BITS, ARR_FAIL, seen, f1, mask = '0;
  logic [63:0] w = 64'h80000001F0F05A5A;
  logic [7:0]  lat = 8'h05;
  int          num_errors = 0, samples_checked = 0, cycles = 0, n_done = 0;
  always #20 CORE_CLK = ~CORE_CLK;
  opw_prog_ctrl i_dut (.CORE_CLK(CORE_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .ARR_ADDR(ARR_ADDR), .ARR_BITS(ARR_BITS), .ARR_PROG(ARR_PROG),
    .ARR_DONE(ARR_DONE), .ARR_FAIL(ARR_FAIL));
  opw_array_model i_arr (.clk(CORE_CLK), .rst(RST), .prog(ARR_PROG), .bits(ARR_BITS), .mask(mask), .lat(lat),
    .done(ARR_DONE), .fail(ARR_FAIL));
  function automatic logic [71:0] cw(input logic [63:0] d);
    logic [7:0] c;
    c = '0;
    for (int i = 0; i < 64; i++) c[i % 8] ^= d[i];
    return {c, d};
  endfunction
  task automatic results;
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge CORE_CLK) begin
    cycles++;
    if (ARR_PROG && ARR_DONE) begin
      n_done++;
      seen = ARR_BITS;
      seen_addr = ARR_ADDR;
    end
    // Whole run needs under a hundred cycles; a hang ends here
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic go(input logic [31:0] d);
    bus(1'b1, opw_pkg::ADDR_PCTRL, d);
    repeat (2) @(posedge CORE_CLK);
    while (ARR_PROG) @(posedge CORE_CLK);
  endtask
  initial begin
    repeat (5) @(posedge CORE_CLK);
    RST <= 1'b0;
    rd(opw_pkg::ADDR_PCTRL, opw_pkg::PCTRL_RESET);
    rd(opw_pkg::ADDR_STAT, 32'h00000001);
    bus(1'b1, opw_pkg::ADDR_PWORD0, w[31:0]);
    bus(1'b1, opw_pkg::ADDR_PWORD1, w[63:32]);
    // Data loaded first, so a start wrongly taken outside the mode would reach the array
    go(32'h00008123);
    `CHK(n_done, 0)
    rd(opw_pkg::ADDR_STAT, 32'h00000001);
    bus(1'b1, opw_pkg::ADDR_MODE, {29'h0, opw_pkg::MODE_MANUAL_PROG});
    rd(opw_pkg::ADDR_MODE, {29'h0, opw_pkg::MODE_MANUAL_PROG});
    rd(opw_pkg::ADDR_PWORD0, w[31:0]);
    rd(opw_pkg::ADDR_PWORD1, w[63:32]);
    // Two bits refuse on the slow first pass, so the retry has work
    mask <= 72'h000000000000000202;
    f1 = cw(w) & 72'h000000000000000202;
    go(32'hFFFFBABC);
    `CHK(seen, cw(w))
    `CHK(seen_addr, 13'h1ABC)
    `CHK(n_done, 1)
    rd(opw_pkg::ADDR_PCTRL, 32'h00001ABC);
    rd(opw_pkg::ADDR_STAT, 32'h00000005);
    mask <= '0;
    lat <= 8'h00;
    go(32'h0000DABC);
    `CHK(seen, f1)
    `CHK(n_done, 2)
    rd(opw_pkg::ADDR_STAT, 32'h00000001);
    go(32'h0000DABC);
    `CHK(n_done, 2)
    rd(opw_pkg::ADDR_STAT, 32'h00000009);
    rd(32'h07F40020, 32'h00000000);
    results();
  end
endmodule // tb
`default_nettype wire
